//--- test/cpwm_bridge_model.sv
/*
 half-bridge gate model driven by the stage's pin pairs
 assumes the bench mirrors the polarities; a released gate is pulled off
*/
module cpwm_bridge_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  hi_lvl,
	input  wire logic [2:0]  hi_oe,
	input  wire logic [2:0]  lo_lvl,
	input  wire logic [2:0]  lo_oe,
	input  wire logic [2:0]  hi_pol,
	input  wire logic [2:0]  lo_pol,
	output logic      [15:0] shoot_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hi_on; // high switch conducting
	logic [2:0] lo_on; // low switch conducting
	// released gate is pulled to off
	assign hi_on = hi_oe & (hi_lvl ^ hi_pol);
	assign lo_on = lo_oe & (lo_lvl ^ lo_pol);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shoot_cnt <= 16'h0000;
		end else if ((hi_on & lo_on) != 3'h0) begin
			shoot_cnt <= shoot_cnt + 16'h0001;
		end
	end
endmodule

//--- test/tb_top.sv
/*
 self-checking bench for the complementary output stage
 assumes a zero-wait apb slave and the bridge model beside it
*/
`include "cpwm_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pcs;          // prepared compare levels
	logic        break_pin;
	logic        crystal_fail;
	logic [3:0]  primary_out;
	logic [3:0]  primary_oe;
	logic [2:0]  complementary_out;
	logic [2:0]  complementary_oe;
	logic        break_irq;
	logic [2:0]  hi_pol;       // mirrored primary polarities
	logic [2:0]  lo_pol;       // mirrored comp polarities
	logic [15:0] shoot_cnt;
	logic [31:0] rd;           // last read data
	logic        err;          // last slave error
	int          n_errors;
	int          checks;
	// ----------------------------------------
	// design and power stage
	// ----------------------------------------
	cpwm_stage dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prepared_compare_signal(pcs), .break_pin(break_pin), .crystal_fail(crystal_fail),
		.primary_out(primary_out), .primary_oe(primary_oe), .complementary_out(complementary_out),
		.complementary_oe(complementary_oe), .break_irq(break_irq));
	cpwm_bridge_model bridge (.clk(clk), .rst_n(rst_n), .hi_lvl(primary_out[2:0]),
		.hi_oe(primary_oe[2:0]), .lo_lvl(complementary_out), .lo_oe(complementary_oe),
		.hi_pol(hi_pol), .lo_pol(lo_pol), .shoot_cnt(shoot_cnt));
	// free-running clock
	always #4 clk = ~clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, held until pready, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		cmp(what, exp, rd);
	endtask
	// channel config, polarity mirror follows one edge later
	task automatic cfg(input logic [31:0] d);
		wr(`CPWM_CHCFG_ADDR, d);
		hi_pol <= {d[18], d[10], d[2]};
		lo_pol <= {d[19], d[11], d[3]};
	endtask
	task automatic wait_irq(input logic v);
		int n;
		n = 0;
		while (break_irq !== v && n < 60) begin
			@(posedge clk);
			n++;
		end
		cmp("irq level", {31'h0, v}, {31'h0, break_irq});
		if (n >= 60) begin
			give_verdict();
		end
	endtask
	// channel 0 as {level, enable} primary then comp
	function automatic logic [31:0] pins0();
		pins0 = {28'h0, primary_out[0], primary_oe[0], complementary_out[0], complementary_oe[0]};
	endfunction
	// channel 1 as {level, enable} primary then comp
	function automatic logic [31:0] pins1();
		pins1 = {28'h0, primary_out[1], primary_oe[1], complementary_out[1], complementary_oe[1]};
	endfunction
	// levels of channels 0 and 2
	function automatic logic [31:0] pair();
		pair = {28'h0, primary_out[0], primary_out[2], complementary_out[0], complementary_out[2]};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdc("ctrl", `CPWM_CTRL_ADDR, 32'h00000000);
		rdc("dtime", `CPWM_DTIME_ADDR, 32'h00000000);
		rdc("chcfg", `CPWM_CHCFG_ADDR, 32'h00000000);
		rdc("status", `CPWM_STATUS_ADDR, 32'h00000000);
		apb(1'b0, 8'h10, 32'h00000000);
		cmp("unmapped err", 32'h00000001, {31'h0, err});
		cmp("unmapped data", 32'h00000000, rd);
		wr(8'h10, 32'hFFFFFFFF);
		rdc("ctrl kept", `CPWM_CTRL_ADDR, 32'h00000000);
		wr(`CPWM_DTIME_ADDR, 32'h000001A5);
		rdc("dtime field", `CPWM_DTIME_ADDR, 32'h000000A5);
		wr(`CPWM_DTIME_ADDR, 32'h00000000);
		cfg(32'h3F000000);
		rdc("last channel cfg", `CPWM_CHCFG_ADDR, 32'h15000000);
	endtask
	// entries: ros, {pol_c, pol_p, en_c, en_p}, expected pins; same config on every channel
	task automatic t_table();
		logic [11:0] tab [7] = '{12'h000, 12'h054, 12'h0A1, 12'h03D, 12'h1CF, 12'h11D, 12'h127};
		pcs <= 4'hF;
		for (int i = 0; i < 7; i++) begin
			cfg({4'h0, tab[i][7:4], 4'h0, tab[i][7:4], 4'h0, tab[i][7:4], 4'h0, tab[i][7:4]});
			wr(`CPWM_CTRL_ADDR, {30'h0, tab[i][8], 1'b1});
			cyc(4);
			cmp("run pins", {28'h0, tab[i][3:0]}, pins0());
			cmp("ch1 pins", {28'h0, tab[i][3:0]}, pins1());
			cmp("ch3 pins", {30'h0, tab[i][3:2]}, {30'h0, primary_out[3], primary_oe[3]});
		end
		wr(`CPWM_CTRL_ADDR, 32'h00000000);
		cfg(32'h00000000);
		cyc(4);
		cmp("idle off pins", 32'h00000000, pins0());
	endtask
	task automatic t_dead();
		wr(`CPWM_DTIME_ADDR, 32'h00000006);
		cfg(32'h00030003);
		wr(`CPWM_CTRL_ADDR, 32'h00000001);
		pcs <= 4'h0;
		cyc(10);
		cmp("steady low", 32'h00000003, pair());
		pcs <= 4'h5;
		cyc(3);
		cmp("comp fell", 32'h00000000, pair());
		cyc(3);
		cmp("primary held", 32'h00000000, pair());
		cyc(4);
		cmp("primary rose", 32'h0000000C, pair());
		pcs <= 4'h0;
		cyc(3);
		cmp("primary fell", 32'h00000000, pair());
		cyc(3);
		cmp("comp held", 32'h00000000, pair());
		cyc(4);
		cmp("comp rose", 32'h00000003, pair());
	endtask
	task automatic t_short();
		int hits;
		for (int k = 0; k < 2; k++) begin
			pcs <= {3'h0, k[0]};
			cyc(12);
			pcs <= {3'h0, ~k[0]};
			cyc(3);
			pcs <= {3'h0, k[0]};
			hits = 0;
			repeat (14) begin
				@(posedge clk);
				hits += (k == 0) ? int'(primary_out[0] !== 1'b0) : int'(complementary_out[0] !== 1'b0);
			end
			cmp("short pulse hits", 32'h00000000, hits);
		end
	endtask
	task automatic t_break();
		wr(`CPWM_DTIME_ADDR, 32'h00000002);
		cfg(32'h00000013);
		wr(`CPWM_CTRL_ADDR, 32'h0000003D);
		pcs <= 4'h0;
		cyc(4);
		break_pin <= 1'b1;
		wait_irq(1'b1);
		rdc("ctrl on break", `CPWM_CTRL_ADDR, 32'h0000003C);
		rdc("flag on break", `CPWM_STATUS_ADDR, 32'h00000001);
		cyc(8);
		cmp("idle pins kept", 32'h0000000D, pins0());
		break_pin <= 1'b0;
		cyc(2);
		wr(`CPWM_STATUS_ADDR, 32'h00000001);
		rdc("flag cleared", `CPWM_STATUS_ADDR, 32'h00000000);
		wait_irq(1'b0);
	endtask
	task automatic t_gate();
		wr(`CPWM_CTRL_ADDR, 32'h00000011);
		break_pin <= 1'b1;
		cyc(10);
		rdc("break disabled", `CPWM_CTRL_ADDR, 32'h00000011);
		wr(`CPWM_CTRL_ADDR, 32'h00000009);
		cyc(10);
		rdc("low active idle", `CPWM_CTRL_ADDR, 32'h00000009);
		break_pin <= 1'b0;
		cyc(10);
		rdc("low active break", `CPWM_CTRL_ADDR, 32'h00000008);
		rdc("flag set", `CPWM_STATUS_ADDR, 32'h00000001);
		cmp("irq masked", 32'h00000000, {31'h0, break_irq});
		break_pin <= 1'b1;
		cyc(10);
		wr(`CPWM_STATUS_ADDR, 32'h00000001);
	endtask
	task automatic t_crystal();
		cfg(32'h00000000);
		wr(`CPWM_CTRL_ADDR, 32'h00000010);
		break_pin <= 1'b0;
		cyc(6);
		wr(`CPWM_CTRL_ADDR, 32'h00000019);
		cyc(4);
		rdc("no break yet", `CPWM_CTRL_ADDR, 32'h00000019);
		crystal_fail <= 1'b1;
		cyc(10);
		rdc("crystal break", `CPWM_CTRL_ADDR, 32'h00000018);
		rdc("crystal flag", `CPWM_STATUS_ADDR, 32'h00000001);
		cmp("released pins", 32'h00000000, pins0());
		crystal_fail <= 1'b0;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pcs = 4'h0;
		break_pin = 1'b0;
		crystal_fail = 1'b0;
		hi_pol = 3'h0;
		lo_pol = 3'h0;
		n_errors = 0;
		checks = 0;
		cyc(6);
		rst_n <= 1'b1;
		cyc(1);
		t_regs();
		t_table();
		t_dead();
		t_short();
		t_break();
		t_gate();
		t_crystal();
		cmp("shoot count", 32'h00000000, {16'h0000, shoot_cnt});
		give_verdict();
	end
endmodule

//--- verilog/cpwm_pkg.sv
/*
 holds the types shared by the output stage
 assumes nothing beyond the register header
*/
package cpwm_pkg;
	// per-channel output configuration
	typedef struct packed {
		logic idle_level_complementary; // idle level, comp
		logic idle_level_primary;       // idle level, primary
		logic complementary_polarity;   // comp polarity
		logic primary_polarity;         // primary polarity
		logic complementary_out_enable; // comp enable
		logic primary_out_enable;       // primary enable
	} cpwm_chcfg_s;
	// one output pin pair as driven
	typedef struct packed {
		logic lvl; // level
		logic oe;  // output enable
	} cpwm_pin_s;
endpackage

//--- verilog/cpwm_regs.svh
/*
 holds register offsets, field positions and reset values
 assumes 32-bit apb data, one aligned word per register
*/
`ifndef CPWM_REGS_SVH
`define CPWM_REGS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CPWM_CTRL_ADDR   8'h00
`define CPWM_DTIME_ADDR  8'h04
`define CPWM_CHCFG_ADDR  8'h08
`define CPWM_STATUS_ADDR 8'h0C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CPWM_MOE_BIT  0
`define CPWM_ROS_BIT  1
`define CPWM_IOS_BIT  2
`define CPWM_BEN_BIT  3
`define CPWM_BPOL_BIT 4
`define CPWM_BIE_BIT  5
`define CPWM_CTRL_W   6
// status: break flag, write one to clear
`define CPWM_BFLAG_BIT 0
// channel config: 8 bits per channel
`define CPWM_CH_STRIDE 8
`define CPWM_CH_W      6
`define CPWM_DT_W      8
`define CPWM_CTRL_RST  6'h00
`define CPWM_DT_RST    8'h00
`define CPWM_CH_RST    6'h00
`endif

//--- verilog/cpwm_stage.sv
/*
 complementary pwm output stage with dead time and break
 assumes prepared compare signals come from the timer on clk,
 and that break pin and clock-fail arrive asynchronously
*/
// Implementation choices: the APB register port and the register offsets.
// What this block does
// - primary and complementary never both active
// - only channels 0-2 have complementary pair
// - independent polarity for each output
// - primary only: primary follows, comp off
// - comp only: comp follows, primary off
// - both on: comp is inverted prepared signal
// - run, no enables, no ros: both off
// - ros set: disabled output drives polarity
// - idle: inactive first, idle after dead time
// - off-state level equals polarity bit
// - run dead time only with both enables, moe
// - one dead-time setting for channels 0-2
// - rising edge delayed by dead time
// - short pulses stay inactive
// - break from pin or crystal failure
// - break enable and break polarity
// - break clears main output enable
// - ios selects own or kept enables
// - after break idle levels after dead time
// - break sets flag, irq when enabled
// - idle levels never both active
// - prepared signal comes from compare logic
`include "cpwm_regs.svh"
module cpwm_stage (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  prepared_compare_signal,
	input  wire logic        break_pin,
	input  wire logic        crystal_fail,
	output logic      [3:0]  primary_out,
	output logic      [3:0]  primary_oe,
	output logic      [2:0]  complementary_out,
	output logic      [2:0]  complementary_oe,
	output logic             break_irq
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [`CPWM_CTRL_W-1:0] ctrl_reg;  // control bits
	logic [`CPWM_DT_W-1:0]   dt_reg;    // dead_time_setting
	cpwm_pkg::cpwm_chcfg_s   ch_reg [4]; // channel configs
	logic                    bflag_reg; // break_flag
	logic moe, run_offstate_select, idle_offstate_select, ben, bpol, bie;
	assign moe  = ctrl_reg[`CPWM_MOE_BIT];
	assign run_offstate_select  = ctrl_reg[`CPWM_ROS_BIT];
	assign idle_offstate_select  = ctrl_reg[`CPWM_IOS_BIT];
	assign ben  = ctrl_reg[`CPWM_BEN_BIT];
	assign bpol = ctrl_reg[`CPWM_BPOL_BIT];
	assign bie  = ctrl_reg[`CPWM_BIE_BIT];
	logic wr_en;    // write takes effect
	logic brk_act;  // break condition, settled
	logic brk_rise; // new break event
	assign wr_en = psel & penable & pready & pwrite;

	// address decode, used only by the slave error response
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `CPWM_CTRL_ADDR) || (a == `CPWM_DTIME_ADDR) ||
			(a == `CPWM_CHCFG_ADDR) || (a == `CPWM_STATUS_ADDR);
	endfunction

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// ready in access phase, one wait-free cycle after setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

	// read data captured in setup phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				`CPWM_CTRL_ADDR:   prdata[`CPWM_CTRL_W-1:0] <= ctrl_reg;
				`CPWM_DTIME_ADDR:  prdata[`CPWM_DT_W-1:0] <= dt_reg;
				`CPWM_CHCFG_ADDR: begin
					for (int i = 0; i < 4; i++) begin
						prdata[i*`CPWM_CH_STRIDE +: `CPWM_CH_W] <= ch_reg[i];
					end
				end
				`CPWM_STATUS_ADDR: prdata[`CPWM_BFLAG_BIT] <= bflag_reg;
				default:           prdata <= 32'h0000_0000; // unmapped
			endcase
		end
	end

	// control register, break overrides moe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `CPWM_CTRL_RST;
		end else begin
			if (wr_en && paddr == `CPWM_CTRL_ADDR) begin
				ctrl_reg <= pwdata[`CPWM_CTRL_W-1:0];
			end
			if (brk_act) begin
				ctrl_reg[`CPWM_MOE_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dt_reg <= `CPWM_DT_RST;
		end else if (wr_en && paddr == `CPWM_DTIME_ADDR) begin
			dt_reg <= pwdata[`CPWM_DT_W-1:0];
		end
	end

	// channel configs; channel 3 keeps only primary fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				ch_reg[i] <= `CPWM_CH_RST;
			end
		end else if (wr_en && paddr == `CPWM_CHCFG_ADDR) begin
			for (int i = 0; i < 4; i++) begin
				ch_reg[i] <= pwdata[i*`CPWM_CH_STRIDE +: `CPWM_CH_W];
			end
			// no comp fields on channel 3
			ch_reg[3].complementary_out_enable <= 1'b0;
			ch_reg[3].complementary_polarity   <= 1'b0;
			ch_reg[3].idle_level_complementary <= 1'b0;
		end
	end

	// sticky flag, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bflag_reg <= 1'b0;
		end else if (brk_rise) begin
			bflag_reg <= 1'b1;
		end else if (wr_en && paddr == `CPWM_STATUS_ADDR &&
			pwdata[`CPWM_BFLAG_BIT]) begin
			bflag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			break_irq <= 1'b0;
		end else begin
			break_irq <= bflag_reg & bie;
		end
	end

	// ----------------------------------------
	// break input
	// ----------------------------------------
	logic [2:0] bp_sync; // break pin synchroniser
	logic [2:0] cf_sync; // clock-fail synchroniser
	logic       bp_lvl;  // settled pin level
	logic       cf_lvl;  // settled fail level
	logic       brk_d;   // previous break state

	// three stages; change counts when last two agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bp_sync <= 3'h0;
			cf_sync <= 3'h0;
			bp_lvl  <= 1'b0;
			cf_lvl  <= 1'b0;
			brk_d   <= 1'b0;
		end else begin
			bp_sync <= {bp_sync[1:0], break_pin};
			cf_sync <= {cf_sync[1:0], crystal_fail};
			if (bp_sync[1] == bp_sync[2]) begin
				bp_lvl <= bp_sync[2];
			end
			if (cf_sync[1] == cf_sync[2]) begin
				cf_lvl <= cf_sync[2];
			end
			brk_d <= brk_act;
		end
	end

	assign brk_act  = ben & ((bp_lvl ~^ bpol) | cf_lvl);
	assign brk_rise = brk_act & ~brk_d;

	// ----------------------------------------
	// idle dead time after moe falls
	// ----------------------------------------
	logic                  moe_d;    // previous moe
	logic [`CPWM_DT_W-1:0] idle_cnt; // idle delay counter
	logic                  idle_done;

	// restart dead time on entry to idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			moe_d    <= 1'b0;
			idle_cnt <= `CPWM_DT_RST;
		end else begin
			moe_d <= moe;
			if (moe_d & ~moe) begin
				idle_cnt <= dt_reg;
			end else if (idle_cnt != `CPWM_DT_RST) begin
				idle_cnt <= idle_cnt - 1'b1;
			end
		end
	end
	assign idle_done = ~moe & ~moe_d & (idle_cnt == `CPWM_DT_RST);

	// ----------------------------------------
	// complementary channels 0 to 2
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pair
			logic                  p;      // prepared signal
			logic                  p_d;    // previous value
			logic [`CPWM_DT_W-1:0] cnt;    // dead-time counter
			logic                  done;   // dead time elapsed
			cpwm_pkg::cpwm_chcfg_s c;
			cpwm_pkg::cpwm_pin_s   po, co; // next pin values
			logic                  ip, ic; // safe idle levels
			assign p = prepared_compare_signal[g];
			assign c = ch_reg[g];

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					p_d <= 1'b0;
					cnt <= `CPWM_DT_RST;
				end else begin
					p_d <= p;
					if (p != p_d) begin
						cnt <= dt_reg;
					end else if (cnt != `CPWM_DT_RST) begin
						cnt <= cnt - 1'b1;
					end
				end
			end
			// new edge before zero keeps output inactive
			assign done = (p == p_d) && (cnt == `CPWM_DT_RST);

			// if both idle levels active, comp goes inactive
			assign ip = c.idle_level_primary;
			assign ic = ((ip ^ c.primary_polarity) &
				(c.idle_level_complementary ^ c.complementary_polarity)) ?
				c.complementary_polarity : c.idle_level_complementary;

			// next levels and enables
			always_comb begin
				po = '0;
				co = '0;
				if (moe) begin
					if (c.primary_out_enable & c.complementary_out_enable) begin
						po.lvl = (p & done) ^ c.primary_polarity;
						co.lvl = (~p & done) ^ c.complementary_polarity;
						po.oe  = 1'b1;
						co.oe  = 1'b1;
					end else begin
						if (c.primary_out_enable) begin
							po.lvl = p ^ c.primary_polarity;
							po.oe  = 1'b1;
						end else if (run_offstate_select) begin
							po.lvl = c.primary_polarity;
							po.oe  = 1'b1;
						end
						if (c.complementary_out_enable) begin
							co.lvl = p ^ c.complementary_polarity;
							co.oe  = 1'b1;
						end else if (run_offstate_select) begin
							co.lvl = c.complementary_polarity;
							co.oe  = 1'b1;
						end
						// no enables, no ros: low, released
					end
				end else if (idle_offstate_select | c.primary_out_enable |
					c.complementary_out_enable) begin
					// inactive first, idle after dead time
					// idle levels once idle_done, after the idle count reaches zero
					po.lvl = idle_done ? ip : c.primary_polarity;
					co.lvl = idle_done ? ic : c.complementary_polarity;
					// ios keeps enables, else own enable
					po.oe  = idle_offstate_select | c.primary_out_enable;
					co.oe  = idle_offstate_select | c.complementary_out_enable;
				end
			end

			// registered pins
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					primary_out[g]       <= 1'b0;
					primary_oe[g]        <= 1'b0;
					complementary_out[g] <= 1'b0;
					complementary_oe[g]  <= 1'b0;
				end else begin
					primary_out[g]       <= po.lvl;
					primary_oe[g]        <= po.oe;
					complementary_out[g] <= co.lvl;
					complementary_oe[g]  <= co.oe;
				end
			end

			a_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
				!(primary_oe[g] && complementary_oe[g] &&
				primary_out[g] != $past(c.primary_polarity) &&
				complementary_out[g] != $past(c.complementary_polarity)))
				else $error("both outputs active");
		end
	endgenerate

	// ----------------------------------------
	// channel 3, single output
	// ----------------------------------------
	cpwm_pkg::cpwm_chcfg_s c3;
	cpwm_pkg::cpwm_pin_s   p3;
	assign c3 = ch_reg[3];

	// channel 3 has no pair, no run dead time; its idle level still waits for idle_done
	always_comb begin
		p3 = '0;
		if (moe && c3.primary_out_enable) begin
			p3.lvl = prepared_compare_signal[3] ^ c3.primary_polarity;
			p3.oe  = 1'b1;
		end else if (moe ? run_offstate_select : (idle_offstate_select | c3.primary_out_enable)) begin
			p3.lvl = (!moe && idle_done) ? c3.idle_level_primary :
				c3.primary_polarity;
			p3.oe  = 1'b1;
		end
	end

	// registered pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_out[3] <= 1'b0;
			primary_oe[3]  <= 1'b0;
		end else begin
			primary_out[3] <= p3.lvl;
			primary_oe[3]  <= p3.oe;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_brk_clears_moe: assert property (@(posedge clk) disable iff (!rst_n)
		brk_act |=> !moe) else $error("break left moe set");
	a_brk_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
		brk_rise |=> bflag_reg) else $error("break flag not set");
	a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
		(bflag_reg && bie) |=> break_irq) else $error("irq missing");
	a_dead_primary: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(prepared_compare_signal[0]) && moe && dt_reg != 8'h00 &&
		ch_reg[0].primary_out_enable && ch_reg[0].complementary_out_enable)
		|=> primary_out[0] == $past(ch_reg[0].primary_polarity))
		else $error("primary rose without dead time");
	a_comp_falls_now: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(prepared_compare_signal[0]) && moe &&
		ch_reg[0].primary_out_enable && ch_reg[0].complementary_out_enable)
		|=> complementary_out[0] == $past(ch_reg[0].complementary_polarity))
		else $error("comp did not fall at once");
	a_single_primary: assert property (@(posedge clk) disable iff (!rst_n)
		(moe && !run_offstate_select && ch_reg[1].primary_out_enable &&
		!ch_reg[1].complementary_out_enable) |=>
		(primary_out[1] == $past(prepared_compare_signal[1] ^
		ch_reg[1].primary_polarity)) && !complementary_oe[1])
		else $error("primary-only mode wrong");
	a_all_off: assert property (@(posedge clk) disable iff (!rst_n)
		(!run_offstate_select && !idle_offstate_select && !ch_reg[2].primary_out_enable &&
		!ch_reg[2].complementary_out_enable) |=>
		!primary_oe[2] && !complementary_oe[2] && !primary_out[2])
		else $error("disabled pair driven");
	a_idle_first: assert property (@(posedge clk) disable iff (!rst_n)
		($fell(moe) && idle_offstate_select && dt_reg != 8'h00) |=>
		primary_out[0] == $past(ch_reg[0].primary_polarity))
		else $error("idle level before dead time");
	a_ch3_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(moe && ch_reg[3].primary_out_enable) |=>
		primary_out[3] == $past(prepared_compare_signal[3] ^
		ch_reg[3].primary_polarity)) else $error("channel 3 wrong");

	c_break: cover property (@(posedge clk) disable iff (!rst_n) brk_rise);
	c_idle_done: cover property (@(posedge clk) disable iff (!rst_n)
		!moe ##1 idle_done);
	c_dead_pwm: cover property (@(posedge clk) disable iff (!rst_n)
		moe && primary_oe[0] && complementary_oe[0] && primary_out[0]);
endmodule
